// >>> core/txq_rate_pkg.sv
// Constants, register map and field layout of the egress queue rate scheduler.
// Assumes a single 25 MHz system clock shared by bus, fabric and MAC logic.
package txq_rate_pkg;

  localparam int NUM_PORTS  = 3;
  localparam int NUM_QUEUES = 4;
  localparam int QSEL_W     = 2;
  localparam int RATIO_W    = 7;
  localparam int REG_W      = 16;
  localparam int DATA_W     = 32;
  localparam int ADDR_W     = 12;
  localparam int IDX_W      = 10;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] PORT1_HIGH_QUEUE_RATE_CTRL_IDX = 10'h0c8;
  localparam logic [IDX_W-1:0] PORT1_LOW_QUEUE_RATE_CTRL_IDX  = 10'h0ca;
  localparam logic [IDX_W-1:0] PORT2_HIGH_QUEUE_RATE_CTRL_IDX = 10'h0cc;
  localparam logic [IDX_W-1:0] PORT2_LOW_QUEUE_RATE_CTRL_IDX  = 10'h0ce;
  localparam logic [IDX_W-1:0] PORT3_HIGH_QUEUE_RATE_CTRL_IDX = 10'h0d0;
  localparam logic [IDX_W-1:0] PORT3_LOW_QUEUE_RATE_CTRL_IDX  = 10'h0d2;
  localparam logic [IDX_W-1:0] RATE_PERIOD_IDX                = 10'h0f0;
  localparam logic [IDX_W-1:0] SCHED_STATUS_IDX               = 10'h0f1;

  // First register of a port holds the two upper queues, second the two lower
  localparam int RATE_FIRST  = 0;
  localparam int RATE_SECOND = 1;

  localparam logic [IDX_W-1:0] RATE_IDX [NUM_PORTS][2] = '{
    '{PORT1_HIGH_QUEUE_RATE_CTRL_IDX, PORT1_LOW_QUEUE_RATE_CTRL_IDX},
    '{PORT2_HIGH_QUEUE_RATE_CTRL_IDX, PORT2_LOW_QUEUE_RATE_CTRL_IDX},
    '{PORT3_HIGH_QUEUE_RATE_CTRL_IDX, PORT3_LOW_QUEUE_RATE_CTRL_IDX}
  };

  // Field positions inside a rate register
  localparam int MODE_HI_BIT  = 15;
  localparam int RATIO_HI_LSB = 8;
  localparam int MODE_LO_BIT  = 7;
  localparam int RATIO_LO_LSB = 0;

  localparam logic [RATIO_W-1:0] HIGHEST_RATIO_RST = 7'h08;
  localparam logic [RATIO_W-1:0] HIGH_RATIO_RST    = 7'h04;
  localparam logic [RATIO_W-1:0] LOW_RATIO_RST     = 7'h02;
  localparam logic [RATIO_W-1:0] LOWEST_RATIO_RST  = 7'h01;
  localparam logic               MODE_RST          = 1'b1;

  localparam logic [REG_W-1:0] RATE_FIRST_RST  =
    {MODE_RST, HIGH_RATIO_RST, MODE_RST, HIGHEST_RATIO_RST};
  localparam logic [REG_W-1:0] RATE_SECOND_RST =
    {MODE_RST, LOWEST_RATIO_RST, MODE_RST, LOW_RATIO_RST};

  // Period length minus one, in system clock cycles
  localparam logic [REG_W-1:0] PERIOD_RST = 16'h03e8;

  // Status word layout
  localparam int STATUS_CNT_LSB = 0;
  localparam int STATUS_GQ_LSB  = 16;

  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic       HRESP_OKAY = 1'b0;

endpackage : txq_rate_pkg

// >>> core/txq_rate_scheduler.sv
// Egress queue scheduler for three switch ports, four priority queues each.
// Assumes fabric queue status and MAC requests are on the system clock.
// Functional notes
// - Highest queue in strict mode is served before any lower queue while it holds packets.
// - Highest queue in ratio mode sends at most bits 6..0 of the first register per period, reset 0x08.
// - High queue in strict mode is served before any lower queue while it holds packets.
// - High queue in ratio mode sends at most bits 14..8 of the first register per period, reset 0x04.
// - Low queue in strict mode is served before the lowest queue while it holds packets.
// - Low queue in ratio mode sends at most bits 6..0 of the second register per period, reset 0x02.
// - Lowest queue in strict mode sends only when no higher queue is served.
// - Lowest queue in ratio mode sends at most bits 14..8 of the second register per period, reset 0x01.
// - All four mode bits of every port reset to ratio mode.
// - Every port owns its own pair of rate registers.
module txq_rate_scheduler
  import txq_rate_pkg::*;
(
  input  wire logic                                       CLK_SYS_I,
  input  wire logic                                       RST_N_I,
  input  wire logic                                       HSEL_I,
  input  wire logic [DATA_W-1:0]                          HADDR_I,
  input  wire logic [1:0]                                 HTRANS_I,
  input  wire logic                                       HWRITE_I,
  input  wire logic [2:0]                                 HSIZE_I,
  input  wire logic                                       HREADY_I,
  input  wire logic [DATA_W-1:0]                          HWDATA_I,
  output logic      [DATA_W-1:0]                          HRDATA_O,
  output logic                                            HREADYOUT_O,
  output logic                                            HRESP_O,
  input  wire logic [txq_rate_pkg::NUM_PORTS*txq_rate_pkg::NUM_QUEUES-1:0] QUEUE_NONEMPTY_I,
  input  wire logic [txq_rate_pkg::NUM_PORTS-1:0]         MAC_REQ_I,
  output logic      [txq_rate_pkg::NUM_PORTS-1:0]         GRANT_O,
  output logic      [txq_rate_pkg::NUM_PORTS*txq_rate_pkg::QSEL_W-1:0] GRANT_QUEUE_O
);

  typedef struct packed {
    logic [NUM_PORTS-1:0][1:0][REG_W-1:0]                rate;
    logic [REG_W-1:0]                                    period_len;
    logic [REG_W-1:0]                                    period_cnt;
    logic [NUM_PORTS-1:0][NUM_QUEUES-1:0][RATIO_W-1:0]   sent;
    logic [NUM_PORTS-1:0]                                grant;
    logic [NUM_PORTS-1:0][QSEL_W-1:0]                    gq;
    logic                                                ph_act;
    logic                                                ph_wr;
    logic [DATA_W-1:0]                                   ph_addr;
    logic [DATA_W-1:0]                                   rdata;
  } state_t;

  state_t s_q;
  state_t s_d;

  function automatic logic [REG_W-1:0] sel_reg(input logic [1:0][REG_W-1:0] regs,
                                              input int q);
    return (q >= 2) ? regs[RATE_FIRST] : regs[RATE_SECOND];
  endfunction : sel_reg

  // Odd queues sit in the low byte of their register, even queues in the high byte
  function automatic logic q_ratio_mode(input logic [1:0][REG_W-1:0] regs,
                                        input int q);
    logic [REG_W-1:0] r;
    r = sel_reg(regs, q);
    return (q % 2 == 1) ? r[MODE_LO_BIT] : r[MODE_HI_BIT];
  endfunction : q_ratio_mode

  function automatic logic [RATIO_W-1:0] q_limit(input logic [1:0][REG_W-1:0] regs,
                                                 input int q);
    logic [REG_W-1:0] r;
    r = sel_reg(regs, q);
    return (q % 2 == 1) ? r[RATIO_LO_LSB +: RATIO_W] : r[RATIO_HI_LSB +: RATIO_W];
  endfunction : q_limit

  // Word accesses inside the low address window only; everything else is unmapped
  function automatic logic addr_ok(input logic [DATA_W-1:0] a);
    return (a[DATA_W-1:ADDR_W] == '0) && (a[1:0] == 2'h0);
  endfunction : addr_ok

  logic                                     period_end;
  logic                                     found;
  logic [QSEL_W-1:0]                        pick;
  logic [RATIO_W-1:0]                       base;
  logic                                     elig;
  logic [IDX_W-1:0]                         wr_idx;
  logic [IDX_W-1:0]                         rd_idx;
  logic                                     take;

  always_comb begin
    s_d        = s_q;
    s_d.grant  = '0;
    s_d.rdata  = '0;
    found      = 1'b0;
    pick       = '0;
    base       = '0;
    elig       = 1'b0;
    wr_idx     = s_q.ph_addr[ADDR_W-1:2];
    rd_idx     = HADDR_I[ADDR_W-1:2];
    take       = HSEL_I && HREADY_I && HTRANS_I[1];

    // Counts restart on the same edge that wraps the period counter
    period_end     = (s_q.period_cnt >= s_q.period_len);
    s_d.period_cnt = period_end ? '0 : s_q.period_cnt + 16'h0001;

    // Address phase capture; zero wait states, so every phase is taken at once
    s_d.ph_act  = take;
    s_d.ph_wr   = HWRITE_I;
    s_d.ph_addr = (HSIZE_I == HSIZE_WORD) ? HADDR_I : '1;

    // Data phase write; writes to unmapped addresses are dropped silently
    if (s_q.ph_act && s_q.ph_wr && addr_ok(s_q.ph_addr)) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        for (int r = 0; r < 2; r++) begin
          if (wr_idx == RATE_IDX[p][r]) begin
            s_d.rate[p][r] = HWDATA_I[REG_W-1:0];
          end
        end
      end
      if (wr_idx == RATE_PERIOD_IDX) begin
        s_d.period_len = HWDATA_I[REG_W-1:0];
      end
    end

    // Read data is latched at the address phase from the post-write values,
    // so a read right behind a write sees the new contents
    if (take && !HWRITE_I && HSIZE_I == HSIZE_WORD && addr_ok(HADDR_I)) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        for (int r = 0; r < 2; r++) begin
          if (rd_idx == RATE_IDX[p][r]) begin
            s_d.rdata = {16'h0000, s_d.rate[p][r]};
          end
        end
      end
      if (rd_idx == RATE_PERIOD_IDX) begin
        s_d.rdata = {16'h0000, s_d.period_len};
      end
      if (rd_idx == SCHED_STATUS_IDX) begin
        s_d.rdata[STATUS_CNT_LSB +: REG_W] = s_q.period_cnt;
        s_d.rdata[STATUS_GQ_LSB +: NUM_PORTS*QSEL_W] = s_q.gq;
      end
    end

    for (int p = 0; p < NUM_PORTS; p++) begin
      found = 1'b0;
      pick  = '0;
      // Highest eligible queue wins; strict queues are always eligible when
      // non-empty, so they starve everything below them
      for (int q = NUM_QUEUES - 1; q >= 0; q--) begin
        base = period_end ? '0 : s_q.sent[p][q];
        elig = QUEUE_NONEMPTY_I[p*NUM_QUEUES + q] &&
               (!q_ratio_mode(s_q.rate[p], q) ||
                (base < q_limit(s_q.rate[p], q)));
        if (!found && elig) begin
          found = 1'b1;
          pick  = QSEL_W'(q);
        end
      end

      // One grant per request; the cycle after a grant is blocked so the
      // MAC and the fabric status have time to follow
      if (MAC_REQ_I[p] && !s_q.grant[p] && found) begin
        s_d.grant[p] = 1'b1;
        s_d.gq[p]    = pick;
      end

      for (int q = 0; q < NUM_QUEUES; q++) begin
        base = period_end ? '0 : s_q.sent[p][q];
        // Counting only in ratio mode keeps the count below the 7-bit limit
        if (s_d.grant[p] && pick == QSEL_W'(q) && q_ratio_mode(s_q.rate[p], q)) begin
          s_d.sent[p][q] = base + 7'h01;
        end else begin
          s_d.sent[p][q] = base;
        end
      end
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        s_q.rate[p][RATE_FIRST]  <= RATE_FIRST_RST;
        s_q.rate[p][RATE_SECOND] <= RATE_SECOND_RST;
      end
      s_q.period_len <= PERIOD_RST;
      s_q.period_cnt <= '0;
      s_q.sent       <= '0;
      s_q.grant      <= '0;
      s_q.gq         <= '0;
      s_q.ph_act     <= 1'b0;
      s_q.ph_wr      <= 1'b0;
      s_q.ph_addr    <= '0;
      s_q.rdata      <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign HRDATA_O      = s_q.rdata;
  assign HREADYOUT_O   = 1'b1;
  assign HRESP_O       = HRESP_OKAY;
  assign GRANT_O       = s_q.grant;
  assign GRANT_QUEUE_O = s_q.gq;

endmodule : txq_rate_scheduler

// >>> verif/txq_rate_scheduler_props.sv
// Port checker for the egress queue scheduler.
// Assumes it is bound to txq_rate_scheduler and sees only its ports.
module txq_rate_scheduler_props
  import txq_rate_pkg::*;
(
  input wire logic              CLK_SYS_I,
  input wire logic              RST_N_I,
  input wire logic              HSEL_I,
  input wire logic [1:0]        HTRANS_I,
  input wire logic              HWRITE_I,
  input wire logic              HREADY_I,
  input wire logic [DATA_W-1:0] HRDATA_O,
  input wire logic              HREADYOUT_O,
  input wire logic              HRESP_O,
  input wire logic [11:0]       QUEUE_NONEMPTY_I,
  input wire logic [2:0]        MAC_REQ_I,
  input wire logic [2:0]        GRANT_O,
  input wire logic [5:0]        GRANT_QUEUE_O
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_N_I);
  wire         rd_take = HSEL_I & HREADY_I & HTRANS_I[1] & !HWRITE_I;
  logic [11:0] ne_q;
  // Queue state as the scheduler saw it at its decision edge
  always_ff @(posedge CLK_SYS_I) ne_q <= QUEUE_NONEMPTY_I;
  a_ready_high: assert property (HREADYOUT_O)
    else $error("bus stalled");
  a_resp_okay: assert property (HRESP_O == HRESP_OKAY)
    else $error("error response");
  a_rdata_idle: assert property (!$past(rd_take) |-> HRDATA_O == '0)
    else $error("read data outside data phase");
  a_rdata_upper: assert property (HRDATA_O[31:16] == 16'h0)
    else $error("upper read bits set");
  a_no_back: assert property ((GRANT_O & $past(GRANT_O)) == 3'h0)
    else $error("grants back to back");
  a_grant_req: assert property ((GRANT_O & ~$past(MAC_REQ_I)) == 3'h0)
    else $error("grant without request");
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    a_grant_full: assert property (GRANT_O[p] |-> ne_q[p*4+GRANT_QUEUE_O[2*p+:2]])
      else $error("grant from empty queue");
    a_queue_hold: assert property ($changed(GRANT_QUEUE_O[2*p+:2]) |-> GRANT_O[p])
      else $error("queue index moved without grant");
  end
endmodule : txq_rate_scheduler_props

// >>> verif/mac_drain_model.sv
// Port MAC model: asks for packets on every port, promptly or with random gaps.
// Assumes grants are one-cycle pulses on the system clock.
module mac_drain_model (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       slow_i,
  input  wire logic [2:0] grant_i,
  output logic      [2:0] req_o
);
  // A raised request is held until its grant, so none is withdrawn unanswered
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      req_o <= 3'h0;
    end else begin
      for (int p = 0; p < 3; p++) begin
        req_o[p] <= !slow_i | (req_o[p] ? !grant_i[p] : 1'($urandom_range(1, 0)));
      end
    end
  end
endmodule : mac_drain_model

// >>> verif/txq_rate_scheduler_tb_top.sv
// Self-checking bench: register bus, ratio and strict scheduling, periods.
// Assumes the MAC model and the port checker are compiled before it.
module txq_rate_scheduler_tb_top import txq_rate_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] S1 [5] = '{16'h8400, 16'h0084, 16'h8484, 16'h8484, 16'h8488};
  localparam logic [15:0] S2 [5] = '{16'h8182, 16'h8182, 16'h8100, 16'h0082, 16'h8182};
  localparam logic [3:0]  MK [5] = '{4'hf, 4'h7, 4'h3, 4'h1, 4'hf};
  logic        clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, slow = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = HSIZE_WORD;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, d;
  logic [31:0] w [3][2];
  logic [11:0] ne = 12'hfff;
  logic [1:0]  last [3];
  wire         hready, hresp;
  wire  [2:0]  req, gnt;
  wire  [5:0]  gq;
  int unsigned cnt [3][4], miscompares = 0, compares = 0, ord_bad;
  initial forever #20 clk = ~clk;
  txq_rate_scheduler txq_rate_scheduler_i (.CLK_SYS_I(clk), .RST_N_I(rst_n), .HSEL_I(hsel),
    .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize), .HREADY_I(hready),
    .HWDATA_I(hwdata), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
    .QUEUE_NONEMPTY_I(ne), .MAC_REQ_I(req), .GRANT_O(gnt), .GRANT_QUEUE_O(gq));
  mac_drain_model mac_drain_model_i (.clk_i(clk), .rst_n_i(rst_n), .slow_i(slow),
    .grant_i(gnt), .req_o(req));
  always @(posedge clk) begin
    for (int p = 0; p < 3; p++) begin
      if (gnt[p] === 1'b1) begin
        cnt[p][gq[2*p+:2]]++;
        if (gq[2*p+:2] > last[p]) ord_bad++;
        last[p] = gq[2*p+:2];
      end
    end
  end
  task automatic clr();
    cnt = '{default: 0};
    last = '{default: 2'h3};
    ord_bad = 0;
  endtask : clr
  task automatic report_and_stop();
    if (miscompares == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {20'h0, a};
    @(posedge clk);
    for (n = 0; hready !== 1'b1 && n < 20; n++) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    for (n = n; hready !== 1'b1 && n < 40; n++) @(posedge clk);
    d = hrdata;
    if (n >= 20) begin
      $display("wrong value at %0t: bus timeout", $time);
      miscompares++;
      report_and_stop();
    end
  endtask : ahb
  initial begin
    void'($urandom(32'h152d626d));
    clr();
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    for (int p = 0; p < 3; p++) begin
      for (int r = 0; r < 2; r++) begin
        ahb(1'b0, {RATE_IDX[p][r], 2'h0}, '0);
        chk(d, r ? 32'h8182 : 32'h8488);
      end
    end
    ahb(1'b0, 12'hffc, '0);
    chk(d, '0);
    repeat (800) @(posedge clk);
    for (int p = 0; p < 3; p++) begin
      for (int q = 0; q < 4; q++) chk(cnt[p][q], 32'h1 << q);
    end
    chk(ord_bad, '0);
    for (int p = 0; p < 3; p++) begin
      for (int r = 0; r < 2; r++) begin
        w[p][r] = $urandom();
        ahb(1'b1, {RATE_IDX[p][r], 2'h0}, w[p][r]);
      end
    end
    for (int p = 0; p < 3; p++) begin
      for (int r = 0; r < 2; r++) begin
        ahb(1'b0, {RATE_IDX[p][r], 2'h0}, '0);
        chk(d, {16'h0, w[p][r][15:0]});
      end
    end
    for (int k = 0; k < 5; k++) begin
      for (int p = 0; p < 3; p++) begin
        ahb(1'b1, {RATE_IDX[p][0], 2'h0}, {16'h0, S1[k]});
        ahb(1'b1, {RATE_IDX[p][1], 2'h0}, {16'h0, S2[k]});
      end
      // Short period so that several count resets fit into the run
      if (k == 4) begin
        ahb(1'b1, {RATE_PERIOD_IDX, 2'h0}, 32'd40);
        ahb(1'b0, {RATE_PERIOD_IDX, 2'h0}, '0);
        chk(d, 32'd40);
      end
      ne <= {3{MK[k]}};
      slow <= k[0];
      repeat (3) @(posedge clk);
      clr();
      repeat (k == 4 ? 410 : 100) @(posedge clk);
      for (int p = 0; p < 3; p++) begin
        if (k == 4) chk(32'(cnt[p][0] >= 9 && cnt[p][0] <= 11), 32'h1);
        for (int q = 0; q < 4 && k < 4; q++) begin
          chk(q == 3 - k ? 32'(cnt[p][q] > 8) : cnt[p][q], 32'(q == 3 - k));
        end
      end
    end
    report_and_stop();
  end
endmodule : txq_rate_scheduler_tb_top
bind txq_rate_scheduler txq_rate_scheduler_props txq_rate_scheduler_props_i (.CLK_SYS_I,
  .RST_N_I, .HSEL_I, .HTRANS_I, .HWRITE_I, .HREADY_I, .HRDATA_O, .HREADYOUT_O, .HRESP_O,
  .QUEUE_NONEMPTY_I, .MAC_REQ_I, .GRANT_O, .GRANT_QUEUE_O);
